// [area4_pin_sync.sv]
// two flip-flop synchroniser for the external pin inputs
module area4_pin_sync
   import area4_sram_pkg::*;
#(
   parameter int WIDTH = 33,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // the first stage is read only by the second
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         meta_reg <= RESET_VALUE;
         sync_reg <= RESET_VALUE;
      end
      else if (i_clk_en)
      begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

// [area4_sram_pkg.sv]
// shared constants, field layout and helpers for the area 4 sram wait timing block
package area4_sram_pkg;

   // timing: the external bus clock is derived at half the system rate, one tick is half a cycle
   localparam int SYS_CLK_MHZ = 250;
   localparam int BUS_CLK_MHZ = 125;
   localparam int TICKS_PER_BUS_CYCLE = SYS_CLK_MHZ / BUS_CLK_MHZ;
   localparam logic [6:0] STROBE_BASE_TICKS = 7'(TICKS_PER_BUS_CYCLE);

   // apb map
   localparam int APB_ADDR_W = 12;
   localparam logic [APB_ADDR_W-1:0] ADDR_WAIT_CTRL = 12'h000;

   // field positions in the area configuration word
   localparam int BIT_BYTE_STROBE_SEL = 20;
   localparam int POS_WRITE_WAIT = 16;
   localparam int POS_SETUP_DELAY = 11;
   localparam int POS_READ_WAIT = 7;
   localparam int BIT_EXT_WAIT_MASK = 6;
   localparam int POS_HOLD_DELAY = 0;

   localparam logic [31:0] CFG_WRITABLE_MASK = 32'h0017_1fc3;
   localparam logic [31:0] CFG_RESET = 32'h0000_0500;

   localparam logic [3:0] READ_WAIT_CODE_24 = 4'hc;

   typedef struct packed {
      logic byte_strobe_select;
      logic [2:0] write_wait_count;
      logic [1:0] setup_delay;
      logic [3:0] read_wait_count;
      logic ext_wait_mask;
      logic [1:0] hold_delay;
   } wait_cfg_t;

   typedef struct packed {
      logic write;
      logic [25:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } mem_req_t;

   typedef struct packed {
      logic [25:0] addr;
      logic chip_select_n;
      logic read_n;
      logic rd_wr;
      logic [3:0] byte_enable_n;
      logic [31:0] data_out;
      logic data_oe;
   } mem_pins_t;

   localparam mem_pins_t PINS_IDLE = '{addr: 26'h0, chip_select_n: 1'b1, read_n: 1'b1,
      rd_wr: 1'b1, byte_enable_n: 4'hf, data_out: 32'h0, data_oe: 1'b0};

   function automatic wait_cfg_t unpack_cfg(input logic [31:0] word);
      wait_cfg_t c;
      c.byte_strobe_select = word[BIT_BYTE_STROBE_SEL];
      c.write_wait_count = word[POS_WRITE_WAIT +: 3];
      c.setup_delay = word[POS_SETUP_DELAY +: 2];
      c.read_wait_count = word[POS_READ_WAIT +: 4];
      c.ext_wait_mask = word[BIT_EXT_WAIT_MASK];
      c.hold_delay = word[POS_HOLD_DELAY +: 2];
      return c;
   endfunction

   function automatic logic [31:0] pack_cfg(input wait_cfg_t c);
      logic [31:0] w;
      w = 32'h0;
      w[BIT_BYTE_STROBE_SEL] = c.byte_strobe_select;
      w[POS_WRITE_WAIT +: 3] = c.write_wait_count;
      w[POS_SETUP_DELAY +: 2] = c.setup_delay;
      w[POS_READ_WAIT +: 4] = c.read_wait_count;
      w[BIT_EXT_WAIT_MASK] = c.ext_wait_mask;
      w[POS_HOLD_DELAY +: 2] = c.hold_delay;
      return w;
   endfunction

   // half-cycle delay codes: 0.5, 1.5, 2.5, 3.5 bus cycles as ticks
   function automatic logic [6:0] half_delay_ticks(input logic [1:0] code);
      return {4'h0, code, 1'b1};
   endfunction

   function automatic logic [4:0] read_wait_cycles(input logic [3:0] code);
      logic [4:0] n;
      n = 5'h18;
      case (code)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: n = {1'b0, code};
         4'h7: n = 5'h08;
         4'h8: n = 5'h0a;
         4'h9: n = 5'h0c;
         4'ha: n = 5'h0e;
         4'hb: n = 5'h12;
         default: n = 5'h18;
      endcase
      return n;
   endfunction

endpackage

// [area4_sram_wait_timing.sv]
// area 4 sram strobe and wait timing engine with its apb configuration register
//
// Operation
// [RULE_01] Reserved bits 31..21, 19 and 15..13 read as zero and software writes zero to them.
// [RULE_02] Byte strobe select clear: byte enables strobe, rd_wr stays low over a write.
// [RULE_03] Byte strobe select set: byte enables stay low all cycle, rd_wr is the write strobe.
// [RULE_04] Write wait code 000 uses the read wait count, codes 001..111 give zero to six cycles.
// [RULE_05] Setup delay codes 00..11 put 0.5 to 3.5 cycles from select to strobe.
// [RULE_06] Read wait codes 0000..0110 give zero to six cycles, then 8, 10, 12, 14 and 18.
// [RULE_07] Software never programs read wait codes 1101, 1110 or 1111.
// [RULE_08] After reset read wait is 1010; byte strobe, write wait and setup fields are zero.
// [RULE_09] Wait mask clear honours the wait input, set ignores it, even with zero waits.
// [RULE_10] Hold delay codes 00..11 put 0.5 to 3.5 cycles from strobe to select negation.
// [RULE_11] Read wait code 1100 inserts twenty-four wait cycles.
// [RULE_12] All counts are in external bus clock cycles, half cycles taken on the opposite edge.
module area4_sram_wait_timing
   import area4_sram_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [APB_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_req,
   input wire mem_req_t i_req_info,
   output logic o_busy,
   output logic o_done,
   output logic [31:0] o_rdata,
   output logic o_bus_clk,
   output logic [25:0] o_addr,
   output logic o_chip_select_n,
   output logic o_read_n,
   output logic o_rd_wr,
   output logic [3:0] o_byte_enable_n,
   output logic [31:0] o_data_out,
   output logic o_data_oe,
   input wire logic [31:0] i_data_in,
   input wire logic i_ext_wait_n
);

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} eng_state_t;

   // apb register slave
   wait_cfg_t cfg_reg;
   wait_cfg_t cfg_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic addr_hit;
   logic apb_access;

   always_comb
   begin
      cfg_next = cfg_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      addr_hit = (i_paddr == ADDR_WAIT_CTRL);
      apb_access = i_psel && i_penable && pready_reg;
      if (i_clk_en)
      begin
         // zero-wait slave: ready in the cycle after setup, then drops
         pready_next = i_psel && !pready_reg;
         pslverr_next = i_psel && !pready_reg && !addr_hit;
         if (i_psel && !pready_reg)
         begin
            // reserved bits never get stored, so they read back zero
            prdata_next = (addr_hit && !i_pwrite) ? pack_cfg(cfg_reg) : 32'h0; // see [RULE_01]
         end
         if (apb_access && i_pwrite && addr_hit)
         begin
            cfg_next = unpack_cfg(i_pwdata & CFG_WRITABLE_MASK); // see [RULE_01]
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         cfg_reg <= unpack_cfg(CFG_RESET); // see [RULE_08]
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;

   // pin inputs
   logic [32:0] pin_sync;
   logic wait_active;

   area4_pin_sync #(
      .WIDTH(33),
      .RESET_VALUE(33'h1_0000_0000)
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_clk_en(i_clk_en),
      .i_async({i_ext_wait_n, i_data_in}),
      .o_sync(pin_sync)
   );

   assign wait_active = !pin_sync[32];

   // access engine; a snapshot of the configuration keeps an access stable under rewrites
   eng_state_t state_reg;
   eng_state_t state_next;
   logic [6:0] tick_reg;
   logic [6:0] tick_next;
   mem_req_t cur_reg;
   mem_req_t cur_next;
   wait_cfg_t snap_reg;
   wait_cfg_t snap_next;
   logic done_reg;
   logic done_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic bus_clk_reg;
   logic bus_clk_next;
   logic busy_reg;
   logic busy_next;
   logic [4:0] wait_cycles;
   logic [6:0] strobe_ticks;

   area4_wait_decode u_wait_decode (
      .i_read_wait_code(snap_reg.read_wait_count),
      .i_write_wait_code(snap_reg.write_wait_count),
      .i_is_write(cur_reg.write),
      .o_wait_cycles(wait_cycles)
   );

   // one bus cycle of strobe plus two ticks for every wait cycle
   assign strobe_ticks = {1'b0, wait_cycles, 1'b0} + STROBE_BASE_TICKS; // see [RULE_12]

   always_comb
   begin
      state_next = state_reg;
      tick_next = tick_reg;
      cur_next = cur_reg;
      snap_next = snap_reg;
      done_next = 1'b0;
      rdata_next = rdata_reg;
      bus_clk_next = bus_clk_reg;
      if (i_clk_en)
      begin
         bus_clk_next = !bus_clk_reg; // see [RULE_12]
         unique case (state_reg)
            ST_IDLE:
            begin
               // start only on the tick where the bus clock rises
               if (i_req && !bus_clk_reg) // see [RULE_12]
               begin
                  cur_next = i_req_info;
                  snap_next = cfg_reg;
                  state_next = ST_SETUP;
                  tick_next = half_delay_ticks(cfg_reg.setup_delay) - 7'h01; // see [RULE_05]
               end
            end
            ST_SETUP:
            begin
               if (tick_reg == 7'h00)
               begin
                  state_next = ST_STROBE;
                  tick_next = strobe_ticks - 7'h01; // see [RULE_04] see [RULE_06]
               end
               else
               begin
                  tick_next = tick_reg - 7'h01;
               end
            end
            ST_STROBE:
            begin
               if (tick_reg != 7'h00)
               begin
                  tick_next = tick_reg - 7'h01;
               end
               else if (!snap_reg.ext_wait_mask && wait_active) // see [RULE_09]
               begin
                  state_next = ST_STROBE;
               end
               else
               begin
                  state_next = ST_HOLD;
                  tick_next = half_delay_ticks(snap_reg.hold_delay) - 7'h01; // see [RULE_10]
               end
            end
            ST_HOLD:
            begin
               // synced data lags two ticks; the first hold tick still sees strobe data
               if (!cur_reg.write && tick_reg == {4'h0, snap_reg.hold_delay, 1'b0})
               begin
                  rdata_next = pin_sync[31:0];
               end
               if (tick_reg == 7'h00)
               begin
                  state_next = ST_IDLE;
                  done_next = 1'b1;
               end
               else
               begin
                  tick_next = tick_reg - 7'h01;
               end
            end
         endcase
      end
      busy_next = (state_next != ST_IDLE);
   end

   // pin levels follow the next state so that they line up with state_reg
   mem_pins_t pins_reg;
   mem_pins_t pins_next;
   logic pin_active;
   logic pin_strobe;

   always_comb
   begin
      pin_active = (state_next != ST_IDLE);
      pin_strobe = (state_next == ST_STROBE);
      pins_next = PINS_IDLE;
      pins_next.addr = cur_next.addr;
      pins_next.data_out = cur_next.wdata;
      pins_next.chip_select_n = !pin_active;
      pins_next.read_n = !(pin_strobe && !cur_next.write);
      pins_next.data_oe = pin_active && cur_next.write;
      if (!snap_next.byte_strobe_select)
      begin
         pins_next.byte_enable_n = pin_strobe ? ~cur_next.be : 4'hf; // see [RULE_02]
         pins_next.rd_wr = !(pin_active && cur_next.write); // see [RULE_02]
      end
      else
      begin
         pins_next.byte_enable_n = pin_active ? ~cur_next.be : 4'hf; // see [RULE_03]
         pins_next.rd_wr = !(pin_strobe && cur_next.write); // see [RULE_03]
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         state_reg <= ST_IDLE;
         tick_reg <= 7'h00;
         cur_reg <= '0;
         snap_reg <= unpack_cfg(CFG_RESET);
         done_reg <= 1'b0;
         rdata_reg <= 32'h0;
         bus_clk_reg <= 1'b0;
         busy_reg <= 1'b0;
         pins_reg <= PINS_IDLE;
      end
      else
      begin
         state_reg <= state_next;
         tick_reg <= tick_next;
         cur_reg <= cur_next;
         snap_reg <= snap_next;
         done_reg <= done_next;
         rdata_reg <= rdata_next;
         bus_clk_reg <= bus_clk_next;
         busy_reg <= busy_next;
         pins_reg <= pins_next;
      end
   end

   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_rdata = rdata_reg;
   assign o_bus_clk = bus_clk_reg;
   assign o_addr = pins_reg.addr;
   assign o_chip_select_n = pins_reg.chip_select_n;
   assign o_read_n = pins_reg.read_n;
   assign o_rd_wr = pins_reg.rd_wr;
   assign o_byte_enable_n = pins_reg.byte_enable_n;
   assign o_data_out = pins_reg.data_out;
   assign o_data_oe = pins_reg.data_oe;

   // ticks spent in the current state, read only by the checks below
   logic [6:0] age_reg;
   logic [6:0] age_next;

   always_comb
   begin
      age_next = age_reg;
      if (i_clk_en)
      begin
         age_next = (state_next != state_reg) ? 7'h00 : age_reg + 7'h01;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         age_reg <= 7'h00;
      end
      else
      begin
         age_reg <= age_next;
      end
   end

   rsv_read_zero_a: assert property ( // see [RULE_01]
      @(posedge i_sys_clk) disable iff (i_reset)
      (o_pready && !o_pslverr) |-> ((o_prdata & ~CFG_WRITABLE_MASK) == 32'h0))
      else $error("reserved configuration bits read nonzero");

   bas_off_status_a: assert property ( // see [RULE_02]
      @(posedge i_sys_clk) disable iff (i_reset)
      (state_reg != ST_IDLE && cur_reg.write && !snap_reg.byte_strobe_select)
      |-> (!o_rd_wr && ((state_reg == ST_STROBE) == (o_byte_enable_n == ~cur_reg.be))))
      else $error("byte enables not strobing or rd_wr not held in write");

   bas_on_status_a: assert property ( // see [RULE_03]
      @(posedge i_sys_clk) disable iff (i_reset)
      (state_reg != ST_IDLE && snap_reg.byte_strobe_select)
      |-> (o_byte_enable_n == ~cur_reg.be
           && o_rd_wr == !(state_reg == ST_STROBE && cur_reg.write)))
      else $error("byte enables not held or rd_wr not strobing");

   write_wait_map_a: assert property ( // see [RULE_04]
      @(posedge i_sys_clk) disable iff (i_reset)
      (state_reg == ST_STROBE && cur_reg.write)
      |-> (wait_cycles == ((snap_reg.write_wait_count == 3'h0)
           ? read_wait_cycles(snap_reg.read_wait_count)
           : ({2'b00, snap_reg.write_wait_count} - 5'h01))))
      else $error("write wait count mismatch");

   setup_len_a: assert property ( // see [RULE_05]
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && state_reg == ST_SETUP && state_next == ST_STROBE)
      |-> (age_reg == {4'h0, snap_reg.setup_delay, 1'b0}))
      else $error("setup delay length wrong");

   strobe_len_a: assert property ( // see [RULE_06]
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && state_reg == ST_STROBE && state_next == ST_HOLD && snap_reg.ext_wait_mask)
      |-> (age_reg == {1'b0, wait_cycles, 1'b0} + 7'h01))
      else $error("strobe width does not match wait count");

   cfg_reset_a: assert property ( // see [RULE_08]
      @(posedge i_sys_clk) disable iff (i_reset)
      $past(i_reset) |-> (pack_cfg(cfg_reg) == CFG_RESET && state_reg == ST_IDLE))
      else $error("configuration not at reset value");

   ext_wait_hold_a: assert property ( // see [RULE_09]
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && state_reg == ST_STROBE && !snap_reg.ext_wait_mask && wait_active)
      |=> (state_reg == ST_STROBE && !o_read_n == !cur_reg.write))
      else $error("external wait not honoured");

   hold_len_a: assert property ( // see [RULE_10]
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && state_reg == ST_HOLD && state_next == ST_IDLE)
      |-> (age_reg == {4'h0, snap_reg.hold_delay, 1'b0} && !o_chip_select_n)
      ##1 (o_chip_select_n && o_done))
      else $error("hold delay length wrong");

   code_24_a: assert property ( // see [RULE_11]
      @(posedge i_sys_clk) disable iff (i_reset)
      (!cur_reg.write && snap_reg.read_wait_count == READ_WAIT_CODE_24)
      |-> (wait_cycles == 5'h18))
      else $error("read wait code 1100 not 24 cycles");

   half_tick_a: assert property ( // see [RULE_12]
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && state_reg == ST_IDLE && state_next == ST_SETUP)
      |-> (!o_bus_clk ##1 (o_bus_clk && !o_chip_select_n)))
      else $error("access not aligned to bus clock rise");

endmodule

// [area4_wait_decode.sv]
// decodes the read and write wait fields into a wait cycle count
module area4_wait_decode
   import area4_sram_pkg::*;
(
   input wire logic [3:0] i_read_wait_code,
   input wire logic [2:0] i_write_wait_code,
   input wire logic i_is_write,
   output logic [4:0] o_wait_cycles
);

   always_comb
   begin
      o_wait_cycles = read_wait_cycles(i_read_wait_code); // see [RULE_06] see [RULE_11]
      if (i_is_write && i_write_wait_code != 3'h0)
      begin
         o_wait_cycles = {2'b00, i_write_wait_code} - 5'h01; // see [RULE_04]
      end
   end

endmodule

// [sram_partner.sv]
// behavioural external memory with a wait line, seen from the pins
module sram_partner
   import area4_sram_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic [7:0] i_wait_len,
   input wire logic [25:0] i_addr,
   input wire logic i_chip_select_n,
   input wire logic i_read_n,
   input wire logic i_rd_wr,
   input wire logic [3:0] i_byte_enable_n,
   input wire logic [31:0] i_data_out,
   input wire logic i_data_oe,
   output logic [31:0] o_data_in,
   output logic o_ext_wait_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [int];
   logic [31:0] noise = 32'h5a5a_a5a5;
   logic [31:0] word;
   int n_low = 0;
   // a released bus shows a changing pattern, so a late sample never sees old data
   always @*
   begin
      o_data_in = noise;
      if (!i_chip_select_n && !i_read_n && mem.exists(int'(i_addr)))
         o_data_in = mem[int'(i_addr)];
   end
   // wait is raised from select onwards so a short strobe still sees it in time
   assign o_ext_wait_n = !(!i_chip_select_n && n_low < int'(i_wait_len));
   always @(posedge i_sys_clk)
   begin
      noise <= ~noise;
      n_low <= i_chip_select_n ? 0 : n_low + 1;
      // direction low and a lane low together mark the write strobe in both modes
      if (!i_chip_select_n && !i_rd_wr && i_data_oe && i_byte_enable_n != 4'hf)
      begin
         word = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 32'h0;
         for (int k = 0; k < 4; k++)
            if (!i_byte_enable_n[k])
               word[8*k +: 8] = i_data_out[8*k +: 8];
         mem[int'(i_addr)] = word;
      end
   end
endmodule

// [testbench.sv]
// self-checking bench for the area 4 sram wait timing block
`define CHK(got, exp, what) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED t=%0t %s", $time, what); end end
module testbench
   import area4_sram_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata, data_out, data_in, q;
   logic pready, pslverr, busy, done, bus_clk, cs_n, read_n, rd_wr, data_oe, ext_wait_n, e;
   logic [25:0] addr;
   logic [3:0] be_n, be_seen;
   logic [7:0] wait_len = 8'h0;
   mem_req_t req_info = '0;
   wait_cfg_t cfg;
   logic cur_wr = 1'b0, cur_bas = 1'b0;
   int mismatches = 0, tests_run = 0;
   int n_cs, n_pre, n_stb, n_be, n_rw;
   logic [31:0] seed = 32'hb5a7172f;
   logic [31:0] exp_mem [int];
   int rw_tab [16] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24, 24, 24, 24};

   always #2 sys_clk = ~sys_clk;

   area4_sram_wait_timing dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_clk_en(1'b1),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_req(req), .i_req_info(req_info), .o_busy(busy), .o_done(done), .o_rdata(rdata),
      .o_bus_clk(bus_clk), .o_addr(addr), .o_chip_select_n(cs_n), .o_read_n(read_n),
      .o_rd_wr(rd_wr), .o_byte_enable_n(be_n), .o_data_out(data_out), .o_data_oe(data_oe),
      .i_data_in(data_in), .i_ext_wait_n(ext_wait_n));

   sram_partner mem_dev (.i_sys_clk(sys_clk), .i_wait_len(wait_len), .i_addr(addr),
      .i_chip_select_n(cs_n), .i_read_n(read_n), .i_rd_wr(rd_wr), .i_byte_enable_n(be_n),
      .i_data_out(data_out), .i_data_oe(data_oe), .o_data_in(data_in),
      .o_ext_wait_n(ext_wait_n));

   // pin monitor: phases of one access counted in system cycles (ticks)
   always @(posedge sys_clk)
      if (cs_n === 1'b0)
      begin
         n_cs++;
         if (!read_n || (cur_wr && (cur_bas ? !rd_wr : be_n != 4'hf)))
            n_stb++;
         else if (n_stb == 0)
            n_pre++;
         if (be_n != 4'hf)
         begin
            n_be++;
            be_seen = ~be_n;
         end
         if (!rd_wr)
            n_rw++;
      end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic timed_out();
      mismatches++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      give_verdict();
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         timed_out();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so that the next call never re-drives psel in this time step
      @(posedge sys_clk);
   endtask

   // software keeps reserved bits at zero in normal traffic
   task automatic set_cfg(input wait_cfg_t c);
      cfg = c;
      apb(1'b1, ADDR_WAIT_CTRL, {11'h0, c.byte_strobe_select, 1'b0, c.write_wait_count, 3'h0,
         c.setup_delay, c.read_wait_count, c.ext_wait_mask, 4'h0, c.hold_delay});
   endtask

   task automatic acc(input logic wr, input int a, input logic [31:0] d, input logic [3:0] be,
      input logic exact);
      int n;
      int w;
      int stb_x;
      logic [31:0] m;
      w = (wr && cfg.write_wait_count != 3'h0) ? int'(cfg.write_wait_count) - 1
         : rw_tab[cfg.read_wait_count];
      stb_x = 2 * (1 + w);
      cur_wr = wr;
      cur_bas = cfg.byte_strobe_select;
      {n_cs, n_pre, n_stb, n_be, n_rw} = '0;
      be_seen = 4'h0;
      req <= 1'b1;
      req_info <= '{write: wr, addr: 26'(a), wdata: d, be: be};
      n = 0;
      while (busy !== 1'b1 && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      req <= 1'b0;
      while (done !== 1'b1 && n < 400)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 400)
         timed_out();
      `CHK(n_pre, 2 * int'(cfg.setup_delay) + 1, "setup length")
      `CHK(n_cs - n_pre - n_stb, 2 * int'(cfg.hold_delay) + 1, "hold length")
      if (exact)
         `CHK(n_stb, stb_x, "strobe length")
      else
         `CHK(n_stb > stb_x && n_stb <= stb_x + 14, 1'b1, "wait stretch")
      `CHK(n_be, cur_bas ? n_cs : n_stb, "lane span")
      `CHK(n_rw, wr ? (cur_bas ? n_stb : n_cs) : 0, "direction span")
      `CHK(be_seen, be, "byte lanes")
      if (wr)
      begin
         m = exp_mem.exists(a) ? exp_mem[a] : 32'h0;
         for (int k = 0; k < 4; k++)
            if (be[k])
               m[8*k +: 8] = d[8*k +: 8];
         exp_mem[a] = m;
      end
      else
         `CHK(rdata, exp_mem[a], "read data")
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, ADDR_WAIT_CTRL, 32'h0);
      `CHK(q, 32'h0000_0500, "reset value")
      apb(1'b1, ADDR_WAIT_CTRL, 32'hffff_ffff);
      apb(1'b1, 12'h004, 32'h0);
      `CHK(e, 1'b1, "unmapped write error")
      apb(1'b0, ADDR_WAIT_CTRL, 32'h0);
      `CHK(q, 32'h0017_1fc3, "reserved bits read zero")
      `CHK(e, 1'b0, "mapped read error")
      $display("test registers done");
      // every read code 0..12, every write, setup and hold code, both lane modes
      // the prohibited read wait codes above 12 are never used in an access
      for (int i = 0; i <= 12; i++)
      begin
         set_cfg({i[0], 3'(i), 2'(i), 4'(i), 1'b1, 2'(i + 1)});
         seed = lfsr(seed);
         acc(1'b1, i * 4, seed, 4'hf, 1'b1);
         seed = lfsr(seed);
         acc(1'b1, i * 4, seed, seed[7:4] | 4'h8, 1'b1);
         acc(1'b0, i * 4, 32'h0, 4'hf, 1'b1);
         $display("test timing code %0d done", i);
      end
      // zero programmed waits: wait input honoured, then masked
      wait_len <= 8'h08;
      set_cfg(13'h0000);
      acc(1'b0, 4, 32'h0, 4'hf, 1'b0);
      set_cfg(13'h0004);
      acc(1'b0, 4, 32'h0, 4'hf, 1'b1);
      wait_len <= 8'h00;
      $display("test external wait done");
      reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, ADDR_WAIT_CTRL, 32'h0);
      `CHK(q, 32'h0000_0500, "value after second reset")
      $display("test second reset done");
      give_verdict();
   end
endmodule
